/* ann_pkg.sv */
package ann_pkg;

   // Anomaly severity classes
   typedef enum logic [1:0]
   {
      ANN_CLS_WARN   = 2'b00,
      ANN_CLS_UNLOAD = 2'b01,
      ANN_CLS_DEACT  = 2'b10,
      ANN_CLS_ALARM  = 2'b11
   } ann_class_t;

   // Register write strobe from the serial slave
   typedef struct packed
   {
      logic        wr;
      logic [15:0] addr;
      logic [15:0] data;
   } ann_regwr_t;

   // Register offsets
   localparam logic [15:0] ANN_REG_QUICK_COMMAND    = 16'h0014;
   localparam logic [15:0] ANN_REG_COMMAND_PASSWORD = 16'h0065;
   localparam logic [15:0] ANN_REG_COMMAND_CODE     = 16'h0066;

   // Command values
   localparam logic [15:0] ANN_QUICK_ACK      = 16'h0002;
   localparam logic [15:0] ANN_CODE_SILENCE   = 16'h0033;
   localparam logic [15:0] ANN_CODE_ACK       = 16'h0034;

   // Horn duration setting
   localparam int          ANN_HORN_DUR_W     = 10;
   localparam logic [9:0]  ANN_HORN_DISABLED  = 10'h000;
   localparam logic [9:0]  ANN_HORN_ENDLESS   = 10'h3e7;

   // Timing
   localparam longint      ANN_CLK_HZ         = 40000000;
   localparam longint      ANN_TICK_S         = 1;
   localparam longint      ANN_PW_TIMEOUT_S   = 5;
   localparam longint      ANN_TICK_CYC       = ANN_TICK_S * ANN_CLK_HZ;
   localparam longint      ANN_PW_TIMEOUT_CYC = ANN_PW_TIMEOUT_S * ANN_CLK_HZ;

endpackage

/* ann_annunciator.sv */
// Summary of operation
// [RULE_01] Four classes; warnings never stop engine
// [RULE_02] Unload: ramp down, then open breaker; code ramps only in parallel mode, else opens breaker at once
// [RULE_03] Deactivation: open breaker, cooled engine stop
// [RULE_04] Alarm: open breaker, immediate engine stop
// [RULE_05] New alarm only with no alarm active
// [RULE_06] New deactivation needs no alarm/deactivation
// [RULE_07] New unload needs no higher/unload active
// [RULE_08] New warning needs no higher class active
// [RULE_09] Bypass option admits every anomaly
// [RULE_10] Activation sounds internal and external horn
// [RULE_11] Flash lamp by class and display code
// [RULE_12] Non-warnings disconnect generator, stop engine
// [RULE_13] Hold until acknowledged; auto-clear acked warnings
// [RULE_14] Key silences first, acknowledges second
// [RULE_15] Acknowledge input edge silences horn
// [RULE_16] Password then code within five seconds
// [RULE_17] Code 51 silences; 52 acknowledges too
// [RULE_18] Quick command 2 acknowledges and silences
// [RULE_19] Horn duration: off, endless or timed
// [RULE_20] Acknowledge applies to all anomalies at once
// [RULE_21] Horn time counted in seconds, restarts
// [RULE_22] Late or wrong password ignores code
`timescale 1ns/1ps
module ann_annunciator
   import ann_pkg::*;
#(
   parameter int     N_ANOM     = 8,
   parameter longint TICK_CYC   = ANN_TICK_CYC,
   parameter longint PW_TIMEOUT = ANN_PW_TIMEOUT_CYC
)
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic [N_ANOM-1:0]         anom_cause,
   input  wire logic [2*N_ANOM-1:0]       anom_class,
   input  wire logic                      prio_bypass,
   input  wire logic                      parallel_mode,
   input  wire logic                      ramp_done,
   input  wire logic                      cancel_cmd,
   input  wire logic [ANN_HORN_DUR_W-1:0] horn_duration,
   input  wire logic                      horn_ext_cfg,
   input  wire logic [15:0]               password_cfg,
   input  wire logic                      serial_enable_cfg,
   input  wire logic                      serial_enable_input_function,
   input  wire logic                      ack_key,
   input  wire logic                      ack_input_function,
   input  wire ann_regwr_t                regwr,
   output logic                           horn_int,
   output logic                           horn_ext,
   output logic                           warn_lamp_flash,
   output logic                           alarm_lamp_flash,
   output logic                           display_flash,
   output logic                           ramp_down_req,
   output logic                           generator_breaker_open,
   output logic                           engine_stop_cool,
   output logic                           engine_stop_now,
   output logic                           restart_block,
   output logic [N_ANOM-1:0]              anom_active,
   output logic [N_ANOM-1:0]              anom_unacked
);

   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int PW = $clog2(PW_TIMEOUT + 1);

   // Pin synchronisers
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [1:0] edge_hist;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1     <= 3'h0;
         sync2     <= 3'h0;
         edge_hist <= 2'h0;
      end
      else if (ce)
      begin
         sync1     <= {serial_enable_input_function, ack_input_function, ack_key};
         sync2     <= sync1;
         edge_hist <= sync2[1:0];
      end
   end

   logic key_edge;
   logic di_edge;
   logic ser_ok;

   assign key_edge = sync2[0] & ~edge_hist[0];
   assign di_edge  = sync2[1] & ~edge_hist[1];                     // RULE_15
   assign ser_ok   = ~serial_enable_cfg | sync2[2];                // RULE_16
   // Class decode per entry
   logic [N_ANOM-1:0] m_warn;
   logic [N_ANOM-1:0] m_unl;
   logic [N_ANOM-1:0] m_dea;
   logic [N_ANOM-1:0] m_alm;
   generate
      for (genvar i = 0; i < N_ANOM; i++)
      begin : g_cls
         assign m_warn[i] = anom_class[2*i +: 2] == ANN_CLS_WARN;   // RULE_01
         assign m_unl[i]  = anom_class[2*i +: 2] == ANN_CLS_UNLOAD;
         assign m_dea[i]  = anom_class[2*i +: 2] == ANN_CLS_DEACT;
         assign m_alm[i]  = anom_class[2*i +: 2] == ANN_CLS_ALARM;
      end
   endgenerate
   // Anomaly state
   logic [N_ANOM-1:0] active;
   logic [N_ANOM-1:0] acked;
   logic [N_ANOM-1:0] next_active;
   logic [N_ANOM-1:0] next_acked;
   logic [N_ANOM-1:0] admit;
   logic              any_alm;
   logic              any_dea;
   logic              any_unl;
   assign any_alm = |(active & m_alm);
   assign any_dea = |(active & m_dea);
   assign any_unl = |(active & m_unl);
   // Serial and key commands
   logic          pw_ok;
   logic [PW-1:0] pw_cnt;
   logic          next_pw_ok;
   logic [PW-1:0] next_pw_cnt;
   logic          cmd_silence;
   logic          cmd_ack;
   logic          wr_pw;
   logic          wr_code;
   logic          horn_on;

   assign wr_pw   = regwr.wr && regwr.addr == ANN_REG_COMMAND_PASSWORD;
   assign wr_code = regwr.wr && regwr.addr == ANN_REG_COMMAND_CODE && pw_ok && ser_ok;

   always_comb
   begin
      next_pw_ok  = pw_ok;
      next_pw_cnt = pw_cnt;
      cmd_silence = di_edge | (key_edge & horn_on);                // RULE_14 RULE_15
      cmd_ack     = key_edge & ~horn_on;                           // RULE_14
      if (pw_ok)
      begin
         if (pw_cnt == PW'(PW_TIMEOUT - 1))
            next_pw_ok = 1'b0;                                     // RULE_22
         else
            next_pw_cnt = pw_cnt + PW'(1);
      end
      if (wr_code)
      begin
         next_pw_ok = 1'b0;
         if (regwr.data == ANN_CODE_SILENCE)
            cmd_silence = 1'b1;                                    // RULE_17
         if (regwr.data == ANN_CODE_ACK)
         begin
            cmd_silence = 1'b1;                                    // RULE_17
            cmd_ack     = 1'b1;
         end
      end
      if (wr_pw)
      begin
         next_pw_ok  = ser_ok && regwr.data == password_cfg;       // RULE_16 RULE_22
         next_pw_cnt = '0;
      end
      if (regwr.wr && regwr.addr == ANN_REG_QUICK_COMMAND && regwr.data == ANN_QUICK_ACK)
      begin
         cmd_silence = 1'b1;                                       // RULE_18
         cmd_ack     = 1'b1;
      end
   end

   always_comb
   begin
      next_active = active;
      next_acked  = acked;
      admit       = '0;
      for (int i = 0; i < N_ANOM; i++)
      begin
         if (active[i] && acked[i] && !anom_cause[i] && (m_warn[i] || cancel_cmd))
         begin
            next_active[i] = 1'b0;                                 // RULE_13
            next_acked[i]  = 1'b0;
         end
         else if (active[i] && cmd_ack)
            next_acked[i] = 1'b1;                                  // RULE_20
         if (!active[i] && anom_cause[i])
         begin
            if (prio_bypass)
               admit[i] = 1'b1;                                    // RULE_09
            else if (m_alm[i])
               admit[i] = !any_alm;                                // RULE_05
            else if (m_dea[i])
               admit[i] = !any_alm && !any_dea;                    // RULE_06
            else if (m_unl[i])
               admit[i] = !any_alm && !any_dea && !any_unl;        // RULE_07
            else
               admit[i] = !any_alm && !any_dea && !any_unl;        // RULE_08
         end
         if (admit[i])
         begin
            next_active[i] = 1'b1;
            next_acked[i]  = 1'b0;
         end
      end
   end
   // Horn timing
   logic                      next_horn_on;
   logic [TW-1:0]             tick_cnt;
   logic [TW-1:0]             next_tick_cnt;
   logic [ANN_HORN_DUR_W-1:0] sec_cnt;
   logic [ANN_HORN_DUR_W-1:0] next_sec_cnt;

   always_comb
   begin
      next_horn_on  = horn_on;
      next_tick_cnt = tick_cnt;
      next_sec_cnt  = sec_cnt;
      if (horn_on)
      begin
         if (tick_cnt == TW'(TICK_CYC - 1))
         begin
            next_tick_cnt = '0;                                    // RULE_21
            next_sec_cnt  = sec_cnt + ANN_HORN_DUR_W'(1);
         end
         else
            next_tick_cnt = tick_cnt + TW'(1);
         if (horn_duration != ANN_HORN_ENDLESS && next_sec_cnt >= horn_duration)
            next_horn_on = 1'b0;                                   // RULE_19
      end
      if (cmd_silence)
         next_horn_on = 1'b0;                                      // RULE_14
      if (|admit)
      begin
         next_horn_on  = 1'b1;                                     // RULE_10
         next_tick_cnt = '0;                                       // RULE_21
         next_sec_cnt  = '0;
      end
      if (horn_duration == ANN_HORN_DISABLED)
         next_horn_on = 1'b0;                                      // RULE_19
   end
   // Output decode from next state
   logic [N_ANOM-1:0] nx_unack;
   logic              nx_alm;
   logic              nx_dea;
   logic              nx_unl;
   assign nx_unack = next_active & ~next_acked;
   assign nx_alm   = |(next_active & m_alm);
   assign nx_dea   = |(next_active & m_dea);
   assign nx_unl   = |(next_active & m_unl);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         active                 <= '0;
         acked                  <= '0;
         pw_ok                  <= 1'b0;
         pw_cnt                 <= '0;
         horn_on                <= 1'b0;
         tick_cnt               <= '0;
         sec_cnt                <= '0;
         horn_int               <= 1'b0;
         horn_ext               <= 1'b0;
         warn_lamp_flash        <= 1'b0;
         alarm_lamp_flash       <= 1'b0;
         display_flash          <= 1'b0;
         ramp_down_req          <= 1'b0;
         generator_breaker_open <= 1'b0;
         engine_stop_cool       <= 1'b0;
         engine_stop_now        <= 1'b0;
         restart_block          <= 1'b0;
         anom_active            <= '0;
         anom_unacked           <= '0;
      end
      else if (ce)
      begin
         active                 <= next_active;
         acked                  <= next_acked;
         pw_ok                  <= next_pw_ok;
         pw_cnt                 <= next_pw_cnt;
         horn_on                <= next_horn_on;
         tick_cnt               <= next_tick_cnt;
         sec_cnt                <= next_sec_cnt;
         horn_int               <= next_horn_on;                                // RULE_10
         horn_ext               <= next_horn_on & horn_ext_cfg;                 // RULE_10
         warn_lamp_flash        <= |(nx_unack & m_warn);                        // RULE_11
         alarm_lamp_flash       <= |(nx_unack & ~m_warn);                       // RULE_11
         display_flash          <= |nx_unack;                                   // RULE_11 RULE_13
         ramp_down_req          <= nx_unl & parallel_mode & ~nx_alm & ~nx_dea;  // RULE_02
         generator_breaker_open <= nx_alm | nx_dea |
                                   (nx_unl & (~parallel_mode | ramp_done));     // RULE_02 RULE_12
         engine_stop_cool       <= (nx_unl | nx_dea) & ~nx_alm;                 // RULE_03
         engine_stop_now        <= nx_alm;                                      // RULE_04
         restart_block          <= |(nx_unack & ~m_warn);                       // RULE_02 RULE_03
         anom_active            <= next_active;
         anom_unacked           <= nx_unack;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   alarm_admit_a: assert property (ce && !prio_bypass && |(admit & m_alm) |-> !any_alm) // RULE_05
      else $error("alarm admitted over active alarm");
   deact_admit_a: assert property (ce && !prio_bypass && |(admit & m_dea)
                                   |-> !any_alm && !any_dea) // RULE_06
      else $error("deactivation admitted over higher class");
   unload_admit_a: assert property (ce && !prio_bypass && |(admit & m_unl)
                                    |-> !(any_alm || any_dea || any_unl)) // RULE_07
      else $error("unload admitted over higher class");
   warn_admit_a: assert property (ce && !prio_bypass && |(admit & m_warn)
                                  |-> !(any_alm || any_dea || any_unl)) // RULE_08
      else $error("warning admitted over higher class");
   bypass_admit_a: assert property (ce && prio_bypass && |(anom_cause & ~active)
                                    |=> ce |-> |(anom_active & $past(anom_cause & ~active))) // RULE_09
      else $error("bypass did not admit anomaly");
   horn_start_a: assert property (ce && |admit && horn_duration != ANN_HORN_DISABLED
                                  |=> horn_int && (horn_ext == horn_ext_cfg)) // RULE_10
      else $error("horn not started on activation");
   horn_off_a: assert property (ce && horn_duration == ANN_HORN_DISABLED |=> !horn_int) // RULE_19
      else $error("horn sounds with duration zero");
   di_silence_a: assert property (ce && di_edge && !(|admit) |=> !horn_int) // RULE_15
      else $error("input edge did not silence horn");
   ack_all_a: assert property (ce && cmd_ack && !(|admit) |=> !display_flash
                               && !warn_lamp_flash && !alarm_lamp_flash) // RULE_20
      else $error("acknowledge left flashing");
   warn_only_a: assert property (ce && !(|(next_active & ~m_warn))
                                 |=> !generator_breaker_open && !engine_stop_now
                                 && !engine_stop_cool) // RULE_01
      else $error("warning stopped the engine");
   alarm_stop_a: assert property (ce && nx_alm |=> engine_stop_now && generator_breaker_open
                                  && !engine_stop_cool) // RULE_04
      else $error("alarm without immediate stop");
   pw_timeout_a: assert property (ce && pw_ok && pw_cnt == PW'(PW_TIMEOUT - 1) && !wr_pw
                                  |=> !pw_ok) // RULE_22
      else $error("password step outlived timeout");
   alarm_seen_c: cover property (ce && |(admit & m_alm));
   serial_ack_c: cover property (ce && wr_code && regwr.data == ANN_CODE_ACK);
   horn_expire_c: cover property (horn_on && !cmd_silence ##1 !horn_on);
   key_two_step_c: cover property (ce && key_edge && horn_on ##[1:50] ce && key_edge && !horn_on);

endmodule

/* ann_host_model.sv */
`timescale 1ns/1ps
module ann_host_model
   import ann_pkg::*;
(
   input  wire logic clk,
   output ann_regwr_t regwr,
   output logic       ack_key,
   output logic       ack_input_function,
   output logic       serial_enable_input_function
);

   initial
   begin
      regwr = '{1'b0, 16'h0000, 16'h0000};
      ack_key = 1'b0;
      ack_input_function = 1'b0;
      serial_enable_input_function = 1'b1;
   end

   // Serial enable pin level
   task automatic set_enable(input logic v);
      @(negedge clk);
      serial_enable_input_function <= v;
   endtask

   // One-cycle write, address and data scrambled when idle
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      regwr <= '{1'b1, a, d};
      @(negedge clk);
      regwr <= '{1'b0, ~a, ~d};
   endtask

   // Password step, then command code after a gap
   task automatic cmd(input logic [15:0] pw, input logic [15:0] code, input int gap);
      wr(ANN_REG_COMMAND_PASSWORD, pw);
      repeat (gap) @(negedge clk);
      wr(ANN_REG_COMMAND_CODE, code);
   endtask

   // Key or input pulse, long enough for the synchronisers
   task automatic press(input logic on_input);
      @(negedge clk);
      {ack_input_function, ack_key} <= on_input ? 2'b10 : 2'b01;
      repeat (6) @(negedge clk);
      {ack_input_function, ack_key} <= 2'b00;
      repeat (6) @(negedge clk);
   endtask

endmodule

/* ann_annunciator_bench.sv */
`timescale 1ns/1ps
module ann_annunciator_bench
   import ann_pkg::*;
;
   localparam logic [15:0] PW = 16'h1234;

   logic             clk;
   logic             rst;
   logic             ce;
   logic [4:0]       cause;
   logic             bypass;
   logic             par;
   logic             rdone;
   logic             cancel;
   logic [9:0]       dur;
   logic             ext;
   logic             secfg;
   logic             h_int;
   logic             h_ext;
   logic             wlf;
   logic             alf;
   logic             dfl;
   logic             rdr;
   logic             gbo;
   logic             esc;
   logic             esn;
   logic             rbl;
   logic [4:0]       act;
   logic [4:0]       unack;
   ann_regwr_t       regwr;
   logic             key;
   logic             din;
   logic             sen;
   int               fails;
   int               tests_run;

   wire [9:0] st = {h_int, h_ext, wlf, alf, dfl, rdr, gbo, esc, esn, rbl};

   ann_host_model u_host
   (
      .clk                          (clk),
      .regwr                        (regwr),
      .ack_key                      (key),
      .ack_input_function           (din),
      .serial_enable_input_function (sen)
   );

   ann_annunciator
   #(
      .N_ANOM     (5),
      .TICK_CYC   (10),
      .PW_TIMEOUT (50)
   )
   u_dut
   (
      .clk                          (clk),
      .rst                          (rst),
      .ce                           (ce),
      .anom_cause                   (cause),
      .anom_class                   (10'h3e4),
      .prio_bypass                  (bypass),
      .parallel_mode                (par),
      .ramp_done                    (rdone),
      .cancel_cmd                   (cancel),
      .horn_duration                (dur),
      .horn_ext_cfg                 (ext),
      .password_cfg                 (PW),
      .serial_enable_cfg            (secfg),
      .serial_enable_input_function (sen),
      .ack_key                      (key),
      .ack_input_function           (din),
      .regwr                        (regwr),
      .horn_int                     (h_int),
      .horn_ext                     (h_ext),
      .warn_lamp_flash              (wlf),
      .alarm_lamp_flash             (alf),
      .display_flash                (dfl),
      .ramp_down_req                (rdr),
      .generator_breaker_open       (gbo),
      .engine_stop_cool             (esc),
      .engine_stop_now              (esn),
      .restart_block                (rbl),
      .anom_active                  (act),
      .anom_unacked                 (unack)
   );

   always #12.5 clk = ~clk;

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   // Status word, active set and unacknowledged set
   task automatic look(input logic [9:0] es, input logic [4:0] ea, input logic [4:0] eu);
      chk("status", es, st);
      chk("active", 10'(ea), 10'(act));
      chk("unacked", 10'(eu), 10'(unack));
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("unexpected watchdog: expected done seen hang");
      end_of_test();
   end

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      cause = 5'h00;
      bypass = 1'b0;
      par = 1'b1;
      rdone = 1'b0;
      cancel = 1'b0;
      dur = 10'h3e7;
      ext = 1'b1;
      secfg = 1'b0;
      fails = 0;
      tests_run = 0;
      wt(16);
      rst = 1'b0;
      wt(8);
      look(10'h000, 5'h00, 5'h00);
      // Warning: horn and warning lamp, no engine action
      cause = 5'h01;
      wt(3);
      look(10'h3a0, 5'h01, 5'h01);
      u_host.press(1'b0);
      wt(3);
      look(10'h0a0, 5'h01, 5'h01);
      u_host.press(1'b0);
      wt(3);
      look(10'h000, 5'h01, 5'h00);
      cause = 5'h00;
      wt(3);
      look(10'h000, 5'h00, 5'h00);
      // Escalating classes against the priority scheme
      cause = 5'h02;
      wt(3);
      look(10'h375, 5'h02, 5'h02);
      cause = 5'h03;
      wt(3);
      look(10'h375, 5'h02, 5'h02);
      rdone = 1'b1;
      wt(3);
      look(10'h37d, 5'h02, 5'h02);
      cause = 5'h07;
      wt(3);
      look(10'h36d, 5'h06, 5'h06);
      cause = 5'h0f;
      wt(3);
      look(10'h36b, 5'h0e, 5'h0e);
      cause = 5'h1f;
      wt(3);
      look(10'h36b, 5'h0e, 5'h0e);
      bypass = 1'b1;
      wt(3);
      look(10'h3eb, 5'h1f, 5'h1f);
      bypass = 1'b0;
      // Serial commands: refused cases first
      u_host.cmd(16'h4321, ANN_CODE_ACK, 0);
      wt(3);
      look(10'h3eb, 5'h1f, 5'h1f);
      u_host.cmd(PW, ANN_CODE_ACK, 60);
      wt(3);
      look(10'h3eb, 5'h1f, 5'h1f);
      secfg = 1'b1;
      u_host.set_enable(1'b0);
      wt(4);
      u_host.cmd(PW, ANN_CODE_ACK, 0);
      wt(3);
      look(10'h3eb, 5'h1f, 5'h1f);
      u_host.set_enable(1'b1);
      wt(4);
      u_host.cmd(PW, ANN_CODE_SILENCE, 0);
      wt(3);
      look(10'h0eb, 5'h1f, 5'h1f);
      u_host.cmd(PW, ANN_CODE_ACK, 0);
      wt(3);
      look(10'h00a, 5'h1f, 5'h00);
      cause = 5'h00;
      wt(3);
      look(10'h00a, 5'h1e, 5'h00);
      cancel = 1'b1;
      wt(2);
      cancel = 1'b0;
      rdone = 1'b0;
      wt(3);
      look(10'h000, 5'h00, 5'h00);
      // Quick acknowledge with horn sounding
      cause = 5'h01;
      wt(3);
      u_host.wr(ANN_REG_QUICK_COMMAND, ANN_QUICK_ACK);
      wt(3);
      look(10'h000, 5'h01, 5'h00);
      cause = 5'h00;
      wt(3);
      // Cleared cause stays shown; input edge only silences
      cause = 5'h01;
      wt(3);
      cause = 5'h00;
      wt(3);
      look(10'h3a0, 5'h01, 5'h01);
      u_host.press(1'b1);
      wt(3);
      look(10'h0a0, 5'h01, 5'h01);
      u_host.wr(ANN_REG_QUICK_COMMAND, ANN_QUICK_ACK);
      wt(3);
      look(10'h000, 5'h00, 5'h00);
      // Timed horn of three ticks, external horn unconfigured
      dur = 10'h003;
      ext = 1'b0;
      cause = 5'h01;
      wt(3);
      look(10'h2a0, 5'h01, 5'h01);
      wt(15);
      look(10'h2a0, 5'h01, 5'h01);
      wt(30);
      look(10'h0a0, 5'h01, 5'h01);
      u_host.wr(ANN_REG_QUICK_COMMAND, ANN_QUICK_ACK);
      cause = 5'h00;
      wt(3);
      // Horn disabled entirely
      dur = 10'h000;
      cause = 5'h01;
      wt(3);
      look(10'h0a0, 5'h01, 5'h01);
      // Clock enable low freezes every register
      ce = 1'b0;
      cause = 5'h02;
      wt(3);
      look(10'h0a0, 5'h01, 5'h01);
      // Unload outside parallel opens the breaker at once
      par = 1'b0;
      dur = 10'h3e7;
      ce = 1'b1;
      wt(3);
      look(10'h2ed, 5'h03, 5'h03);
      end_of_test();
   end

endmodule
